// ---- rxes_pkg.sv ----
/*
 * Package for the receive error and fault status block: constants and carrier types.
 * Assumes a single receive core clock domain.
 */
package rxes_pkg;

	// ****************************************
	// Constants
	// ****************************************
	localparam int MISMATCH_W = 2;
	localparam int MAX_LEN_W = 15;
	localparam int LEN_W = 16;
	localparam int FAULT_FILT_DEF = 4;
	localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
	localparam logic [7:0] SFD_BYTE = 8'hD5;
	localparam logic [MISMATCH_W-1:0] MISMATCH_ZERO = 2'h0;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic sop;
		logic [55:0] preamble;
		logic [7:0] sfd;
	} rxes_start_t;

	typedef struct packed {
		logic badPreamble;
		logic badSfd;
		logic signalOrderedSetSeen;
		logic truncated;
		logic [MISMATCH_W-1:0] testPatternMismatch;
	} rxes_pulse_t;

	typedef struct packed {
		logic localFault;
		logic remoteFault;
		logic internalLocalFault;
		logic receivedLocalFault;
	} rxes_fault_t;

endpackage

// ---- rxes_status.sv ----
/*
 * Receive error and fault status block: turns receive path events into status pulses
 * and fault levels.
 * Assumes all event inputs come from receive logic on clk; fault cause inputs that come
 * from other domains are synchronised here.
 */
`timescale 1ns/1ps
// How it works
// [RULE1] A packet whose preamble bytes are not all 0x55 drives the invalid-preamble output to 1.
// [RULE2] That invalid-preamble output fires whatever the preamble-checking control says.
// [RULE3] A packet whose delimiter byte is not 0xD5 drives the invalid-delimiter output to 1, ignoring the check control.
// [RULE4] A received Signal ordered-set word drives the signal-ordered-set output to 1.
// [RULE5] Each cycle a 2-bit bus gives the number of test-pattern mismatches, as a one-cycle value.
// [RULE6] The mismatch bus stays zero unless the test-pattern control input is 1.
// [RULE7] The mismatch bus is a plain per-cycle count a management counter can accumulate.
// [RULE8] The truncation output pulses one cycle per cycle in which the packet length passes the 15-bit maximum.
// [RULE9] The combined local-fault level is high while internal or received local fault is high.
// [RULE10] The remote-fault level is 1 while a remote fault is detected and 0 otherwise.
// [RULE11] Internal local fault is high while test pattern generation, bad alignment or high error rate lasts.
// [RULE12] Received local fault goes high after enough local fault words arrive and holds while they persist.
// [RULE13] All outputs are registered on clk and are zero during reset.
module rxes_status import rxes_pkg::*; #(
	parameter int FAULT_FILT = FAULT_FILT_DEF
) (
	input wire logic clk,
	input wire logic nrst,
	input wire rxes_start_t rxStart,
	input wire logic checkPreamble,
	input wire logic signalOrderedSetWord,
	input wire logic testPatternEnable,
	input wire logic [MISMATCH_W-1:0] mismatchCount,
	input wire logic rxDataValid,
	input wire logic rxEop,
	input wire logic [LEN_W-1:0] bytesThisCycle,
	input wire logic [MAX_LEN_W-1:0] maxPacketLen,
	input wire logic testPatternGenActive,
	input wire logic laneAlignBad,
	input wire logic highBerPin,
	input wire logic localFaultWord,
	input wire logic remoteFaultWord,
	input wire logic idleWord,
	output rxes_pulse_t pulseOut,
	output rxes_fault_t faultOut
);

	// ****************************************
	// Parameter check
	// ****************************************
	if (FAULT_FILT < 1 || FAULT_FILT > 255) begin : gBadFilt
		$error("FAULT_FILT out of range");
	end

	// ****************************************
	// Synchronisers for asynchronous fault causes
	// ****************************************
	logic [2:0] asyncIn;
	logic [2:0] syncA_r;
	logic [2:0] syncB_r;
	assign asyncIn = {testPatternGenActive, laneAlignBad, highBerPin};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			syncA_r <= 3'h0;
			syncB_r <= 3'h0;
		end else begin
			syncA_r <= asyncIn;
			syncB_r <= syncA_r;
		end
	end

	// ****************************************
	// Packet length tracking
	// ****************************************
	logic [LEN_W-1:0] pktLen_r;
	logic [LEN_W-1:0] pktLen_nxt;
	logic inPkt_r;
	logic inPkt_nxt;
	logic [LEN_W:0] lenSum;

	always_comb begin
		lenSum = {1'b0, pktLen_r} + {1'b0, bytesThisCycle};
		pktLen_nxt = pktLen_r;
		inPkt_nxt = inPkt_r;
		if (rxStart.sop) begin
			inPkt_nxt = 1'b1;
			pktLen_nxt = '0;
		end
		if (rxDataValid && (inPkt_r || rxStart.sop)) begin
			pktLen_nxt = lenSum[LEN_W] ? {LEN_W{1'b1}}
				: (rxStart.sop ? bytesThisCycle : lenSum[LEN_W-1:0]);
			if (rxEop) begin
				inPkt_nxt = 1'b0;
			end
		end
	end

	// ****************************************
	// Fault state machine for received fault words
	// ****************************************
	typedef enum logic [1:0] {
		FS_OK = 2'b00,
		FS_LOCAL = 2'b01,
		FS_REMOTE = 2'b10
	} rxes_fstate_t;

	rxes_fstate_t fState_r;
	rxes_fstate_t fState_nxt;
	logic [7:0] faultCnt_r;
	logic [7:0] faultCnt_nxt;
	logic [7:0] lastSeq_r;
	logic [7:0] lastSeq_nxt;
	logic faultWord;
	logic sameKind;
	logic [7:0] filtLimit;

	assign faultWord = localFaultWord || remoteFaultWord;
	assign sameKind = localFaultWord ? lastSeq_r[0] : lastSeq_r[1];
	assign filtLimit = 8'(FAULT_FILT);

	always_comb begin
		fState_nxt = fState_r;
		faultCnt_nxt = faultCnt_r;
		lastSeq_nxt = lastSeq_r;
		if (faultWord) begin
			lastSeq_nxt = {6'h00, remoteFaultWord, localFaultWord};
			if (sameKind && faultCnt_r != 8'hFF) begin
				faultCnt_nxt = faultCnt_r + 8'h01;
			end else if (!sameKind) begin
				faultCnt_nxt = 8'h01;
			end
			if ((sameKind ? faultCnt_r + 8'h01 : 8'h01) >= filtLimit) begin
				fState_nxt = localFaultWord ? FS_LOCAL : FS_REMOTE; // [RULE12]
			end
		end else if (idleWord) begin
			faultCnt_nxt = 8'h00;
			lastSeq_nxt = 8'h00;
			fState_nxt = FS_OK;
		end
	end

	// ****************************************
	// Status outputs
	// ****************************************
	rxes_pulse_t pulse_nxt;
	rxes_fault_t fault_nxt;

	always_comb begin
		pulse_nxt = '0;
		if (rxStart.sop) begin
			pulse_nxt.badPreamble = rxStart.preamble != {7{PREAMBLE_BYTE}}; // [RULE1] [RULE2]
			pulse_nxt.badSfd = rxStart.sfd != SFD_BYTE; // [RULE3]
		end
		pulse_nxt.signalOrderedSetSeen = signalOrderedSetWord; // [RULE4]
		pulse_nxt.testPatternMismatch = testPatternEnable ? mismatchCount : MISMATCH_ZERO; // [RULE5] [RULE6] [RULE7]
		pulse_nxt.truncated = (inPkt_r || rxStart.sop) && rxDataValid
			&& (pktLen_nxt > {1'b0, maxPacketLen}); // [RULE8]
		fault_nxt.internalLocalFault = |syncB_r; // [RULE11]
		fault_nxt.receivedLocalFault = fState_nxt == FS_LOCAL; // [RULE12]
		fault_nxt.remoteFault = fState_nxt == FS_REMOTE; // [RULE10]
		fault_nxt.localFault = fault_nxt.internalLocalFault
			|| fault_nxt.receivedLocalFault; // [RULE9]
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pktLen_r <= '0;
			inPkt_r <= 1'b0;
			fState_r <= FS_OK;
			faultCnt_r <= 8'h00;
			lastSeq_r <= 8'h00;
			pulseOut <= '0; // [RULE13]
			faultOut <= '0;
		end else begin
			pktLen_r <= pktLen_nxt;
			inPkt_r <= inPkt_nxt;
			fState_r <= fState_nxt;
			faultCnt_r <= faultCnt_nxt;
			lastSeq_r <= lastSeq_nxt;
			pulseOut <= pulse_nxt;
			faultOut <= fault_nxt;
		end
	end

endmodule // rxes_status

// ---- rxes_status_monitor.sv ----
/* Checker for the receive status block.
 * Assumes it is bound to rxes_status. */
`timescale 1ns/1ps
module rxes_status_monitor import rxes_pkg::*; #(
	parameter int FAULT_FILT = FAULT_FILT_DEF
) (
	input wire logic clk,
	input wire logic nrst,
	input wire rxes_start_t rxStart,
	input wire logic signalOrderedSetWord,
	input wire logic testPatternEnable,
	input wire logic [MISMATCH_W-1:0] mismatchCount,
	input wire logic remoteFaultWord,
	input wire rxes_pulse_t pulseOut,
	input wire rxes_fault_t faultOut
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_rfRun; remoteFaultWord [*4]; endsequence
	property p_pre; rxStart.sop && rxStart.preamble != {7{PREAMBLE_BYTE}}
		|=> pulseOut.badPreamble; endproperty
	a_pre: assert property (p_pre) else $error("pre");
	property p_sfd; rxStart.sop && rxStart.sfd != SFD_BYTE |=> pulseOut.badSfd; endproperty
	a_sfd: assert property (p_sfd) else $error("sfd");
	property p_sos; signalOrderedSetWord |=> pulseOut.signalOrderedSetSeen; endproperty
	a_sos: assert property (p_sos) else $error("sos");
	property p_mm; testPatternEnable
		|=> pulseOut.testPatternMismatch == $past(mismatchCount); endproperty
	a_mm: assert property (p_mm) else $error("mm");
	property p_mmOff; !testPatternEnable
		|=> pulseOut.testPatternMismatch == MISMATCH_ZERO; endproperty
	a_mmOff: assert property (p_mmOff) else $error("mmOff");
	property p_lf; faultOut.internalLocalFault || faultOut.receivedLocalFault
		|-> ##[0:1] faultOut.localFault; endproperty
	a_lf: assert property (p_lf) else $error("lf");
	property p_rf; s_rfRun |=> faultOut.remoteFault; endproperty
	a_rf: assert property (p_rf) else $error("rf");
	property p_rst; disable iff (1'b0) !nrst |-> pulseOut == '0 && faultOut == '0; endproperty
	a_rst: assert property (p_rst) else $error("rst");
endmodule // rxes_status_monitor
bind rxes_status rxes_status_monitor #(.FAULT_FILT(FAULT_FILT)) i_mon (.clk(clk), .nrst(nrst),
	.rxStart(rxStart), .signalOrderedSetWord(signalOrderedSetWord),
	.testPatternEnable(testPatternEnable), .mismatchCount(mismatchCount),
	.remoteFaultWord(remoteFaultWord), .pulseOut(pulseOut), .faultOut(faultOut));

// ---- rxes_link_partner.sv ----
/* Link partner model sending fault or idle columns.
 * Assumes mode changes off the sampling edge. */
`timescale 1ns/1ps
module rxes_link_partner (
	input wire logic [1:0] mode,
	output logic lfw,
	output logic rfw,
	output logic idw
);
	assign lfw = mode == 2'h1;
	assign rfw = mode == 2'h2;
	assign idw = mode == 2'h0;
endmodule // rxes_link_partner

// ---- testbench.sv ----
/* Testbench for the receive status block.
 * Assumes package and partner model are compiled first. */
`timescale 1ns/1ps
module testbench import rxes_pkg::*;;
	logic clk = 0, nrst, chkPre = 0, sos = 0, tpEn = 0, dv = 0, eop = 0, tpGen = 0;
	logic laneBad = 0, hiBer = 0;
	logic [1:0] mm = 0, mode = 0;
	logic [15:0] bytes = 0;
	logic [14:0] maxLen = 0;
	logic lfw, rfw, idw;
	rxes_start_t st = '0;
	rxes_pulse_t p;
	rxes_fault_t f;
	int numErrors, checked;
	rxes_status i_dut (.clk(clk), .nrst(nrst), .rxStart(st), .checkPreamble(chkPre),
		.signalOrderedSetWord(sos), .testPatternEnable(tpEn), .mismatchCount(mm),
		.rxDataValid(dv), .rxEop(eop), .bytesThisCycle(bytes), .maxPacketLen(maxLen),
		.testPatternGenActive(tpGen), .laneAlignBad(laneBad), .highBerPin(hiBer),
		.localFaultWord(lfw), .remoteFaultWord(rfw), .idleWord(idw),
		.pulseOut(p), .faultOut(f));
	rxes_link_partner i_lp (.mode(mode), .lfw(lfw), .rfw(rfw), .idw(idw));
	initial begin
		forever #2.5 clk = ~clk;
	end
	task chk(string n, logic [1:0] s, logic [1:0] e);
		checked++;
		if (s !== e) begin
			numErrors++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task endOfTest;
		$display("errors %0d checks %0d", numErrors, checked);
		if (numErrors == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task tStart;
		for (int i = 0; i < 4; i++) begin
			chkPre = i[0];
			st = '{1'b1, i[1] ? {7{PREAMBLE_BYTE}} : 56'h55555555555554, i[1] ? 8'hD4 : SFD_BYTE};
			@(negedge clk);
			chk("pre", p.badPreamble, !i[1]);
			chk("sfd", p.badSfd, i[1]);
		end
		st.sop = 0;
		sos = 1;
		@(negedge clk);
		sos = 0;
		chk("sos", p.signalOrderedSetSeen, 1);
		@(negedge clk);
		chk("sos0", p.signalOrderedSetSeen, 0);
	endtask
	task tMm;
		for (int i = 0; i < 8; i++) begin
			tpEn = i[2];
			mm = i[1:0];
			@(negedge clk);
			chk("mm", p.testPatternMismatch, i[2] ? i[1:0] : 2'h0);
		end
	endtask
	task tTrunc;
		maxLen = 15'h000A;
		bytes = 16'h0008;
		dv = 1;
		for (int i = 0; i < 3; i++) begin
			st.sop = i == 0;
			eop = i == 2;
			@(negedge clk);
			chk("trunc", p.truncated, i > 0);
		end
		dv = 0;
	endtask
	task tFault;
		tpGen = 1;
		repeat (4) @(negedge clk);
		chk("ilf", f.internalLocalFault, 1);
		chk("lf", f.localFault, 1);
		tpGen = 0;
		laneBad = 1;
		repeat (3) @(negedge clk);
		chk("ilfLane", f.internalLocalFault, 1);
		laneBad = 0;
		hiBer = 1;
		repeat (3) @(negedge clk);
		chk("ilfBer", f.internalLocalFault, 1);
		hiBer = 0;
		mode = 1;
		repeat (6) @(negedge clk);
		chk("ilf0", f.internalLocalFault, 0);
		chk("rlf", f.receivedLocalFault, 1);
		mode = 2;
		repeat (6) @(negedge clk);
		chk("rf", f.remoteFault, 1);
		mode = 0;
		repeat (3) @(negedge clk);
		chk("rf0", f.remoteFault, 0);
		chk("lf0", f.localFault, 0);
	endtask
	initial begin
		nrst = 0;
		repeat (4) @(negedge clk);
		nrst = 1;
		@(negedge clk);
		tStart;
		tMm;
		tTrunc;
		tFault;
		endOfTest;
	end
	initial begin
		#5000;
		numErrors++;
		endOfTest;
	end
endmodule // testbench
